// ---- hw/pin_cal_pkg.sv ----
// Package: register map, field layout and carrier types of the pin port and calibration bank
package pin_cal_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_PORT_CONTROL_ADDR = 8'h1e;
  localparam logic [7:0] PIN_OUTPUT_LEVELS_ADDR = 8'h1f;
  localparam logic [7:0] PIN_INPUT_LEVELS_ADDR = 8'h20;
  localparam logic [7:0] OFFSET_COEF_HIGH_ADDR = 8'h21;
  localparam logic [7:0] OFFSET_COEF_MIDDLE_ADDR = 8'h22;
  localparam logic [7:0] OFFSET_COEF_LOW_ADDR = 8'h23;
  localparam logic [7:0] GAIN_COEF_HIGH_ADDR = 8'h24;
  localparam logic [7:0] GAIN_COEF_MIDDLE_ADDR = 8'h25;
  localparam logic [7:0] GAIN_COEF_LOW_ADDR = 8'h26;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 4;
  localparam int OD_PIN_COUNT = 3;          // Only pins 0..2 have open drain
  localparam int MASTER_UNLOCK_BIT = 7;
  localparam int OD_SEL_LSB = 4;
  localparam int START_PIN = 3;             // Pin taken by the start function
  localparam logic [7:0] PORT_CONTROL_RESET = 8'h00;
  localparam logic [3:0] PIN_LEVELS_RESET = 4'h0;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_NOMINAL = 24'h555555;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int GAIN_SHIFT = 22;           // Nominal gain scales by 4/3

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
  } reg_req_t;

  typedef struct packed {
    logic        valid; // One-cycle sample strobe
    logic [23:0] data;  // Signed sample
  } sample_t;
endpackage

// ---- hw/pin_cal_regs.sv ----
// Module: pin port registers, user offset/gain calibration and corrected sample path
//
// Functional notes
// [R1] Pin setting changes need master unlock bit set
// [R2] Open-drain select switches pins 0-2 drive
// [R3] Direction bits 0-3: 0 input, 1 output
// [R4] Output register bits drive output pins
// [R5] Input register returns pin levels, read only
// [R6] Offset is signed 24-bit over 0x21..0x23
// [R7] Nominal gain: offset step gives -4/3 LSB
// [R8] Offset subtracted before gain correction
// [R9] Offset effect scales with gain coefficient
// [R10] Port control resets to 0x00
// [R11] Start function: pin3 input, others outputs
// [R12] Gain defaults near 0x555555, host rewritable
// [R13] Pin inputs pass two synchroniser flops
module pin_cal_regs
  import pin_cal_pkg::*;
#(
  parameter logic [23:0] GAIN_FACTORY = GAIN_NOMINAL
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire reg_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire logic start_func_en_i,
  input wire logic [PIN_COUNT-1:0] pin_in_i,
  output logic [PIN_COUNT-1:0] pin_out_o,
  output logic [PIN_COUNT-1:0] pin_oe_o,
  output logic start_in_o,
  input wire sample_t filt_i,
  output sample_t corr_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff, nxt_ctrl;                // Port control register
  logic [3:0] lvl_ff, nxt_lvl;                  // Output levels
  logic [23:0] offset_ff, nxt_offset;           // User offset coefficient
  logic [23:0] gain_ff, nxt_gain;               // Gain coefficient
  logic [7:0] rdata_ff, nxt_rdata;              // Read answer
  logic rvalid_ff, nxt_rvalid;
  logic [3:0] sync1_ff, sync2_ff;               // Input synchroniser stages
  logic [3:0] oe_ff, nxt_oe;                    // Registered pin drive
  logic [3:0] out_ff, nxt_out;
  sample_t corr_ff, nxt_corr;
  logic [7:0] rd_mux;
  logic unlock;

  assign unlock = ctrl_ff[MASTER_UNLOCK_BIT];

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Reserved upper nibbles read as zero
  always_comb begin
    case (req_i.addr)
      PIN_PORT_CONTROL_ADDR: rd_mux = ctrl_ff;
      PIN_OUTPUT_LEVELS_ADDR: rd_mux = {4'h0, lvl_ff};
      // Pins are not readable while the start function owns them
      PIN_INPUT_LEVELS_ADDR: rd_mux = start_func_en_i ? 8'h00 : {4'h0, sync2_ff}; // [R5] [R11]
      OFFSET_COEF_HIGH_ADDR: rd_mux = offset_ff[23:16];
      OFFSET_COEF_MIDDLE_ADDR: rd_mux = offset_ff[15:8];
      OFFSET_COEF_LOW_ADDR: rd_mux = offset_ff[7:0];
      GAIN_COEF_HIGH_ADDR: rd_mux = gain_ff[23:16]; // [R12]
      GAIN_COEF_MIDDLE_ADDR: rd_mux = gain_ff[15:8];
      GAIN_COEF_LOW_ADDR: rd_mux = gain_ff[7:0];
      default: rd_mux = UNMAPPED_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes and read answer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_lvl = lvl_ff;
    nxt_offset = offset_ff;
    nxt_gain = gain_ff;
    nxt_rvalid = req_i.rd;
    nxt_rdata = req_i.rd ? rd_mux : rdata_ff;
    if (req_i.wr) begin
      case (req_i.addr)
        PIN_PORT_CONTROL_ADDR: begin
          // Unlock bit itself is always writable, else software could never open the port
          nxt_ctrl[MASTER_UNLOCK_BIT] = req_i.wdata[MASTER_UNLOCK_BIT]; // [R1]
          if (unlock) begin
            nxt_ctrl[MASTER_UNLOCK_BIT-1:0] = req_i.wdata[MASTER_UNLOCK_BIT-1:0]; // [R1] [R2] [R3]
          end
        end
        PIN_OUTPUT_LEVELS_ADDR: begin
          // Locked or start-owned port ignores level writes
          if (unlock && !start_func_en_i) begin
            nxt_lvl = req_i.wdata[3:0]; // [R1] [R4] [R11]
          end
        end
        OFFSET_COEF_HIGH_ADDR: nxt_offset[23:16] = req_i.wdata; // [R6]
        OFFSET_COEF_MIDDLE_ADDR: nxt_offset[15:8] = req_i.wdata; // [R6]
        OFFSET_COEF_LOW_ADDR: nxt_offset[7:0] = req_i.wdata; // [R6]
        GAIN_COEF_HIGH_ADDR: nxt_gain[23:16] = req_i.wdata; // [R12]
        GAIN_COEF_MIDDLE_ADDR: nxt_gain[15:8] = req_i.wdata; // [R12]
        GAIN_COEF_LOW_ADDR: nxt_gain[7:0] = req_i.wdata; // [R12]
        default: begin
          // Writes to other addresses are dropped
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= PORT_CONTROL_RESET; // [R10]
      lvl_ff <= PIN_LEVELS_RESET;
      offset_ff <= OFFSET_RESET;
      gain_ff <= GAIN_FACTORY; // [R12]
      rdata_ff <= UNMAPPED_READ;
      rvalid_ff <= 1'b0;
    end else if (ce_i) begin
      ctrl_ff <= nxt_ctrl;
      lvl_ff <= nxt_lvl;
      offset_ff <= nxt_offset;
      gain_ff <= nxt_gain;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // First stage feeds only the second stage, to contain metastability
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= PIN_LEVELS_RESET;
      sync2_ff <= PIN_LEVELS_RESET;
    end else if (ce_i) begin
      sync1_ff <= pin_in_i; // [R13]
      sync2_ff <= sync1_ff; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, one generate per pin
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    always_comb begin
      if (start_func_en_i) begin
        // Start pin listens, the rest are held as low outputs
        nxt_oe[p] = (p != START_PIN); // [R11]
        nxt_out[p] = 1'b0;
      end else if (p < OD_PIN_COUNT && ctrl_ff[OD_SEL_LSB + p]) begin
        // Open drain only sinks; a high level releases the pin
        nxt_oe[p] = ctrl_ff[p] && !lvl_ff[p]; // [R2] [R3]
        nxt_out[p] = 1'b0;
      end else begin
        nxt_oe[p] = ctrl_ff[p]; // [R3]
        nxt_out[p] = lvl_ff[p]; // [R4]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_ff <= PIN_LEVELS_RESET;
      out_ff <= PIN_LEVELS_RESET;
    end else if (ce_i) begin
      oe_ff <= nxt_oe;
      out_ff <= nxt_out;
    end
  end

  // ----------------------------------------------------------------
  // Corrected sample path
  // ----------------------------------------------------------------
  // Offset first, gain second, so the offset step follows the gain
  logic signed [24:0] sum;
  logic signed [49:0] prod;
  logic signed [27:0] scaled;
  always_comb begin
    sum = $signed({filt_i.data[23], filt_i.data}) - $signed({offset_ff[23], offset_ff}); // [R6] [R8]
    prod = sum * $signed({1'b0, gain_ff}); // [R7] [R9]
    scaled = prod[GAIN_SHIFT +: 28]; // [R7]
    nxt_corr.valid = filt_i.valid;
    nxt_corr.data = corr_ff.data;
    if (filt_i.valid) begin
      // Saturate rather than wrap at full scale
      if (scaled > 28'sh07fffff) begin
        nxt_corr.data = 24'h7fffff;
      end else if (scaled < -28'sh0800000) begin
        nxt_corr.data = 24'h800000;
      end else begin
        nxt_corr.data = scaled[23:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      corr_ff <= '0;
    end else if (ce_i) begin
      corr_ff <= nxt_corr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_ff;
  assign rvalid_o = rvalid_ff;
  assign pin_out_o = out_ff;
  assign pin_oe_o = oe_ff;
  assign start_in_o = sync2_ff[START_PIN]; // [R11]
  assign corr_o = corr_ff;

endmodule

// ---- bench/pin_cal_regs_assertions.sv ----
// Checker: port timing relations of the pin and calibration bank
module pin_cal_regs_checker import pin_cal_pkg::*; (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire reg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic start_func_en_i,
  input wire logic [PIN_COUNT-1:0] pin_in_i,
  input wire logic [PIN_COUNT-1:0] pin_out_o,
  input wire logic [PIN_COUNT-1:0] pin_oe_o,
  input wire logic start_in_o,
  input wire sample_t filt_i,
  input wire sample_t corr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edges since reset; keeps $past away from reset-time values
  logic [1:0] up_ff;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i) up_ff <= 2'h0;
    else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_read_answer_time: assert property (ce_i && req_i.rd |=> rvalid_o) else $error("read unanswered");
  a_no_stray_answer: assert property (rvalid_o |-> $past(ce_i && req_i.rd)) else $error("stray answer");
  a_rdata_held: assert property (!rvalid_o |-> $stable(rdata_o)) else $error("read data moved");
  a_sample_timing: assert property (ce_i && filt_i.valid ##1 1'b1 |-> corr_o.valid) else $error("sample lost");
  a_corr_held: assert property (!corr_o.valid |-> $stable(corr_o.data)) else $error("output moved");
  a_input_sync_depth: assert property (up_ff == 2'h3 && $past(ce_i) && $past(ce_i, 2) |->
    start_in_o == $past(pin_in_i[START_PIN], 2)) else $error("sync depth wrong");
  a_start_pin_layout: assert property (start_func_en_i [*3] |-> pin_oe_o == 4'h7 && pin_out_o == 4'h0)
    else $error("start layout wrong");
  a_reset_pins_idle: assert property (up_ff == 2'h1 && !$past(start_func_en_i) |-> pin_oe_o == 4'h0
    && pin_out_o == 4'h0) else $error("pins not idle");
  c_input_read: cover property (req_i.rd && req_i.addr == PIN_INPUT_LEVELS_ADDR);
  c_sample_out: cover property (corr_o.valid);
  c_start_mode: cover property (start_func_en_i && pin_oe_o == 4'h7);
endmodule
bind pin_cal_regs pin_cal_regs_checker pin_cal_regs_checker_i (.core_clk_i, .arst_n_i, .ce_i, .req_i, .rdata_o,
  .rvalid_o, .start_func_en_i, .pin_in_i, .pin_out_o, .pin_oe_o, .start_in_o, .filt_i, .corr_o);

// ---- bench/host_model.sv ----
// Host model: register strobes as the serial port decoder would issue them
module host_model import pin_cal_pkg::*; (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output reg_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // One-cycle write; callers unlock before reconfiguring pins
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #2 req_o = '{1'b1, 1'b0, a, d};
    @(posedge clk_i) #2 req_o = '0;
  endtask
  // One-cycle read; a missing answer yields unknown data
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i) #2 req_o = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i) #2 req_o = '0;
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask
endmodule

// ---- bench/testbench.sv ----
// Testbench: register, pin and sample scenarios for the pin and calibration bank
module testbench import pin_cal_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, start_en = 1'b0, rvalid, start_in;
  logic ce = 1'b1; // Clock enable, dropped once to prove the freeze
  logic [3:0] ext_lvl = 4'hf, pin_out, pin_oe, pads; // Far side pulls up when undriven
  logic [7:0] rdata;
  reg_req_t req;
  sample_t filt = '0, corr;
  int fail_count = 0, checks_done = 0, cyc = 0;
  assign pads = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  pin_cal_regs pin_cal_regs_i (.core_clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .start_func_en_i(start_en), .pin_in_i(pads), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .start_in_o(start_in), .filt_i(filt), .corr_o(corr));
  host_model host_model_i (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_i.write_reg(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_model_i.read_reg(a, v);
    chk($sformatf("reg %h", a), {16'h0, exp}, {16'h0, v});
  endtask
  // Offset first, then gain; floor shift matches the chosen rounding
  function automatic logic [23:0] model(input longint x, input longint off, input longint g);
    longint p;
    p = ((x - off) * g) >>> 22;
    return p[23:0];
  endfunction
  task automatic smp(input logic [23:0] x, input logic [23:0] exp);
    @(posedge clk) #2 filt = '{1'b1, x};
    @(posedge clk) #2 filt.valid = 1'b0;
    chk("corr", {exp[22:0], 1'b1}, {corr.data[22:0], corr.valid});
    chk("corr sign", {23'h0, exp[23]}, {23'h0, corr.data[23]});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  // Hang guard, well above the under one hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #2 arst_n = 1'b1;
    rd(8'h1e, 8'h00);
    chk("oe", 24'h0, {20'h0, pin_oe});
    $display("test reset done");
    wr(8'h1e, 8'h0f);
    rd(8'h1e, 8'h00);
    wr(8'h1e, 8'h80);
    wr(8'h1e, 8'h8f);
    wr(8'h1f, 8'hfa);
    rd(8'h1e, 8'h8f);
    rd(8'h1f, 8'h0a);
    chk("drive", 24'h0000fa, {16'h0, pin_oe, pin_out});
    rd(8'h20, 8'h0a);
    $display("test unlock done");
    ext_lvl = 4'he;
    wr(8'h1e, 8'hf3);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h0e);
    chk("open drain", 24'h000018, {16'h0, pin_oe, pin_out});
    start_en = 1'b1;
    wr(8'h1f, 8'h05);
    chk("start pins", 24'h0070, {16'h0, pin_oe, pin_out});
    chk("start in", 24'h000001, {23'h0, start_in});
    rd(8'h20, 8'h00);
    start_en = 1'b0;
    rd(8'h1f, 8'h0a);
    $display("test pins done");
    wr(8'h23, 8'h64);
    rd(8'h23, 8'h64);
    rd(8'h24, 8'h55);
    rd(8'h30, 8'h00);
    smp(24'h0, model(0, 100, 24'h555555));
    wr(8'h21, 8'hff);
    wr(8'h22, 8'hff);
    wr(8'h23, 8'h9c);
    // A write while the enable is low must leave the low byte alone
    ce = 1'b0;
    wr(8'h23, 8'h11);
    ce = 1'b1;
    rd(8'h23, 8'h9c);
    smp(24'h0003e8, model(1000, -100, 24'h555555));
    wr(8'h24, 8'h2a);
    wr(8'h25, 8'haa);
    wr(8'h26, 8'haa);
    smp(24'h0003e8, model(1000, -100, 24'h2aaaaa));
    $display("test offset done");
    give_verdict();
  end
endmodule
